// ===== logic/ads_map.svh
// Register offsets, write masks, reset values and timing counts
`ifndef ADS_MAP_SVH
`define ADS_MAP_SVH
`define ADS_CW           12
`define ADS_NREG         11
`define ADS_CTRL_OFS     8'h00
`define ADS_HTIM_OFS     8'h04
`define ADS_HSYN_OFS     8'h08
`define ADS_VTIM_OFS     8'h0C
`define ADS_VSYN_OFS     8'h10
`define ADS_VGAH_OFS     8'h14
`define ADS_VGAV_OFS     8'h18
`define ADS_VGAVD_OFS    8'h1C
`define ADS_DCMD_OFS     8'h20
`define ADS_DSTAT_OFS    8'h24
`define ADS_GPIO_OFS     8'h28
`define ADS_CTRL_RST     32'h0000_0030
`define ADS_HTIM_RST     32'h0320_0280
`define ADS_HSYN_RST     32'h02F0_0290
`define ADS_VTIM_RST     32'h020D_01E0
`define ADS_VSYN_RST     32'h01EC_01EA
`define ADS_VGAH_RST     32'h505E_5264
`define ADS_VGAV_RST     32'h1EC7_AA0D
`define ADS_VGAVD_RST    32'h0000_01E0
`define ADS_CTRL_MASK    32'h0000_01FF
`define ADS_TIM_MASK     32'h0FFF_0FFF
`define ADS_VGAV_MASK    32'h3FFF_FFFF
`define ADS_VGAVD_MASK   32'h0000_03FF
`define ADS_DCMD_MASK    32'h0000_FFFF
`define ADS_GPIO_MASK    32'h0000_0007
`define ADS_RESP_OK      2'h0
`define ADS_RESP_ERR     2'h2
`define ADS_CLK_KHZ      200000
`define ADS_DDC_KHZ      100
`define ADS_DDC_QTR_CYC  ((`ADS_CLK_KHZ + `ADS_DDC_KHZ * 4 - 1) / (`ADS_DDC_KHZ * 4))
`endif

// ===== logic/ads_pkg.sv
// Types shared by the analog display sync block
`include "ads_map.svh"
package ads_pkg;
   typedef logic [`ADS_CW-1:0] ads_cnt_t;
   typedef struct packed {
      logic ddc1_en;
      logic run;
      logic vga_mode;
      logic vs_idle;
      logic hs_idle;
      logic vs_pol;
      logic hs_pol;
      logic vs_en;
      logic hs_en;
   } ads_ctrl_t;
   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } ads_pixel_t;
   typedef struct packed {
      ads_cnt_t h_act;
      ads_cnt_t h_tot;
      ads_cnt_t hs_s;
      ads_cnt_t hs_e;
      ads_cnt_t v_act;
      ads_cnt_t v_tot;
      ads_cnt_t vs_s;
      ads_cnt_t vs_e;
   } ads_tim_t;
   typedef enum logic [3:0] {
      ADS_ST_IDLE  = 4'b0001,
      ADS_ST_START = 4'b0010,
      ADS_ST_XFER  = 4'b0100,
      ADS_ST_STOP  = 4'b1000
   } ads_state_t;
endpackage

// ===== logic/ads_top.sv
// Analog display sync, pixel output and monitor channel controller
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ads_map.svh"

// Pixel FIFO between the surface fetch and the converter output
module ads_fifo
#(
   parameter int W = 24,
   parameter int D = 8
)
(
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   if (D < 2 || (D & (D - 1)) != 0) $error("ads_fifo depth must be a power of two");
   logic [W-1:0]  mem_ff [D];
   logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [AW:0]   cnt_ff, nxt_cnt;
   logic          rdy_ff, nxt_rdy, push, pop;
   always_comb
   begin
      push = in_valid && rdy_ff;
      pop = out_ready && (cnt_ff != '0);
      nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
      nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
      nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // Registered ready keeps the top output on a flop
      nxt_rdy = nxt_cnt != (AW + 1)'(D);
   end
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
         rdy_ff <= 1'b0;
      end
      else
      begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
         rdy_ff <= nxt_rdy;
      end
      if (push)
         mem_ff[wp_ff] <= in_data;
   end
   assign in_ready = rdy_ff;
   assign out_valid = cnt_ff != '0;
   assign out_data = mem_ff[rp_ff];
endmodule

// Operation
// - Software picks the active polarity of line sync and frame sync separately.
// - Each sync output can be disabled on its own and then holds a software-chosen high or low level.
// - After reset both syncs are disabled and held high until software enables them.
// - Only separate line and frame sync exist, with no composite, panel, stereo or sync-on-green.
// - In legacy mode timing comes from the legacy controller values and the native timing registers are ignored.
// - The monitor channel supports both the vsync-clocked one-way variant and the two-wire bus variant.
// - A hardware serial controller drives the monitor channel clock and data at up to 100 kHz.
// - Monitor channel clock and data sit on general-purpose pins that software can also drive directly.
// - Each pixel leaves as three 8-bit codes, red, green and blue, one per converter channel.
// - The pixel path sustains one pixel per clock, enough for 2048 x 1536 at 60 Hz at 350 MHz.
// - Fetched surface data is streamed in and turned into the output pixel stream.
module ads_top
   import ads_pkg::*;
#(
   parameter int ADDR_W    = 8,
   parameter int FIFO_D    = 8,
   parameter int DDC_QTR   = `ADS_DDC_QTR_CYC
)
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              pix_in_valid,
   input  wire ads_pixel_t        pix_in_data,
   output logic                   pix_in_ready,
   output ads_pixel_t             pix_out,
   output logic                   hsync,
   output logic                   vsync,
   input  wire logic              monitor_channel_clock_i,
   output logic                   monitor_channel_clock_o,
   output logic                   monitor_channel_clock_oe,
   input  wire logic              monitor_channel_data_i,
   output logic                   monitor_channel_data_o,
   output logic                   monitor_channel_data_oe
);
   if (ADDR_W < 6) $error("ads_top needs at least 6 address bits");
   if (DDC_QTR < 2 || DDC_QTR > 65535) $error("ads_top serial divider out of range");

   function automatic logic [31:0] rst_val(input logic [3:0] i);
      case (i)
         4'd0: rst_val = `ADS_CTRL_RST;
         4'd1: rst_val = `ADS_HTIM_RST;
         4'd2: rst_val = `ADS_HSYN_RST;
         4'd3: rst_val = `ADS_VTIM_RST;
         4'd4: rst_val = `ADS_VSYN_RST;
         4'd5: rst_val = `ADS_VGAH_RST;
         4'd6: rst_val = `ADS_VGAV_RST;
         4'd7: rst_val = `ADS_VGAVD_RST;
         default: rst_val = 32'h0000_0000;
      endcase
   endfunction
   function automatic logic [31:0] wmask(input logic [3:0] i);
      case (i)
         4'd0: wmask = `ADS_CTRL_MASK;
         4'd1, 4'd2, 4'd3, 4'd4: wmask = `ADS_TIM_MASK;
         4'd5: wmask = 32'hFFFF_FFFF;
         4'd6: wmask = `ADS_VGAV_MASK;
         4'd7: wmask = `ADS_VGAVD_MASK;
         4'd8: wmask = `ADS_DCMD_MASK;
         4'd10: wmask = `ADS_GPIO_MASK;
         default: wmask = 32'h0000_0000;
      endcase
   endfunction
   function automatic ads_cnt_t lo(input logic [31:0] r);
      lo = r[`ADS_CW-1:0];
   endfunction
   function automatic ads_cnt_t hi(input logic [31:0] r);
      hi = r[`ADS_CW+15:16];
   endfunction
   function automatic ads_cnt_t chr(input logic [7:0] c);
      chr = `ADS_CW'({c, 3'b000});
   endfunction

   // Bus slave state
   logic [31:0]       rf_ff [`ADS_NREG], nxt_rf [`ADS_NREG];
   logic              aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
   logic [ADDR_W-1:0] awa_ff, nxt_awa;
   logic [31:0]       wd_ff, nxt_wd;
   logic [3:0]        ws_ff, nxt_ws;
   logic              bv_ff, nxt_bv, rv_ff, nxt_rv, go_ff, nxt_go, srd_ff, nxt_srd;
   logic [1:0]        br_ff, nxt_br, rr_ff, nxt_rr;
   logic [31:0]       rd_ff, nxt_rd, stat, wm;
   logic [3:0]        widx, ridx;
   // Engine state
   ads_cnt_t   h_ff, nxt_h, v_ff, nxt_v;
   logic       hs_ff, nxt_hs, vs_ff, nxt_vs, vsr_ff, nxt_vsr;
   ads_pixel_t px_ff, nxt_px;
   ads_state_t st_ff, nxt_st;
   logic [15:0] q_ff, nxt_q;
   logic [17:0] gap_ff, nxt_gap;
   logic [1:0]  ph_ff, nxt_ph;
   logic [3:0]  bit_ff, nxt_bit;
   logic        byt_ff, nxt_byt, nak_ff, nxt_nak, sclo_ff, nxt_sclo, sdao_ff, nxt_sdao;
   logic [7:0]  sh_ff, nxt_sh, rx_ff, nxt_rx, d1_ff, nxt_d1;
   logic [2:0]  d1n_ff, nxt_d1n;
   logic        d1v_ff, nxt_d1v;
   ads_ctrl_t  ctrl;
   ads_tim_t   eff;
   logic       hs_raw, vs_raw, active, tick, f_valid;
   ads_pixel_t f_data;

   assign ctrl = ads_ctrl_t'(rf_ff[0][8:0]);
   assign widx = 4'(awa_ff[ADDR_W-1:2]);
   assign ridx = 4'(s_axi_araddr[ADDR_W-1:2]);
   assign wm = wmask(widx);
   assign stat = {13'h0000, d1v_ff, d1_ff, rx_ff, nak_ff, !st_ff[0]};

   always_comb
   begin
      nxt_rf = rf_ff;
      nxt_aw_got = aw_got_ff || (s_axi_awvalid && !aw_got_ff && !bv_ff);
      nxt_awa = (s_axi_awvalid && !aw_got_ff && !bv_ff) ? s_axi_awaddr : awa_ff;
      nxt_w_got = w_got_ff || (s_axi_wvalid && !w_got_ff && !bv_ff);
      nxt_wd = (s_axi_wvalid && !w_got_ff && !bv_ff) ? s_axi_wdata : wd_ff;
      nxt_ws = (s_axi_wvalid && !w_got_ff && !bv_ff) ? s_axi_wstrb : ws_ff;
      nxt_bv = bv_ff && !s_axi_bready;
      nxt_br = br_ff;
      nxt_go = 1'b0;
      nxt_srd = 1'b0;
      if (aw_got_ff && w_got_ff && !bv_ff)
      begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bv = 1'b1;
         // Upper address bits checked too, so high offsets cannot alias onto low registers
         nxt_br = (widx < 4'(`ADS_NREG) && (awa_ff >> 6) == '0 && awa_ff[1:0] == 2'b00) ?
                  `ADS_RESP_OK : `ADS_RESP_ERR;
         if (nxt_br == `ADS_RESP_OK)
         begin
            for (int b = 0; b < 4; b++)
               if (ws_ff[b])
                  nxt_rf[widx][8*b+:8] = wd_ff[8*b+:8] & wm[8*b+:8];
            // A command written while busy is stored but not launched
            nxt_go = widx == 4'(`ADS_DCMD_OFS >> 2) && st_ff[0];
         end
      end
      nxt_rv = rv_ff && !s_axi_rready;
      nxt_rd = rd_ff;
      nxt_rr = rr_ff;
      if (s_axi_arvalid && !rv_ff)
      begin
         nxt_rv = 1'b1;
         nxt_rr = (ridx < 4'(`ADS_NREG) && (s_axi_araddr >> 6) == '0 && s_axi_araddr[1:0] == 2'b00) ?
                  `ADS_RESP_OK : `ADS_RESP_ERR;
         nxt_rd = 32'h0000_0000;
         if (nxt_rr == `ADS_RESP_OK && ridx == 4'(`ADS_DSTAT_OFS >> 2))
         begin
            nxt_rd = stat;
            nxt_srd = 1'b1;
         end
         else if (nxt_rr == `ADS_RESP_OK && ridx == 4'(`ADS_GPIO_OFS >> 2))
            nxt_rd = {27'h0, monitor_channel_data_i, monitor_channel_clock_i, rf_ff[10][2:0]};
         else if (nxt_rr == `ADS_RESP_OK)
            nxt_rd = rf_ff[ridx];
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < `ADS_NREG; i++)
            rf_ff[i] <= rst_val(4'(i));
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awa_ff <= '0;
         wd_ff <= '0;
         ws_ff <= '0;
         bv_ff <= 1'b0;
         br_ff <= `ADS_RESP_OK;
         rv_ff <= 1'b0;
         rr_ff <= `ADS_RESP_OK;
         rd_ff <= '0;
         go_ff <= 1'b0;
         srd_ff <= 1'b0;
      end
      else
      begin
         rf_ff <= nxt_rf;
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         awa_ff <= nxt_awa;
         wd_ff <= nxt_wd;
         ws_ff <= nxt_ws;
         bv_ff <= nxt_bv;
         br_ff <= nxt_br;
         rv_ff <= nxt_rv;
         rr_ff <= nxt_rr;
         rd_ff <= nxt_rd;
         go_ff <= nxt_go;
         srd_ff <= nxt_srd;
      end
   end
   assign s_axi_awready = !aw_got_ff && !bv_ff;
   assign s_axi_wready = !w_got_ff && !bv_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = !rv_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rresp = rr_ff;
   assign s_axi_rdata = rd_ff;

   ads_fifo
   #(
      .W (24),
      .D (FIFO_D)
   )
   u_fifo
   (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (pix_in_valid),
      .in_data   (pix_in_data),
      .in_ready  (pix_in_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (active)
   );

   always_comb
   begin
      if (ctrl.vga_mode)
         eff = '{chr(rf_ff[5][31:24]), chr(rf_ff[5][7:0]), chr(rf_ff[5][15:8]), chr(rf_ff[5][23:16]),
                 lo(rf_ff[7]), `ADS_CW'(rf_ff[6][9:0]), `ADS_CW'(rf_ff[6][19:10]),
                 `ADS_CW'(rf_ff[6][29:20])};
      else
         eff = '{lo(rf_ff[1]), hi(rf_ff[1]), lo(rf_ff[2]), hi(rf_ff[2]),
                 lo(rf_ff[3]), hi(rf_ff[3]), lo(rf_ff[4]), hi(rf_ff[4])};
      hs_raw = ctrl.run && h_ff >= eff.hs_s && h_ff < eff.hs_e;
      vs_raw = ctrl.run && v_ff >= eff.vs_s && v_ff < eff.vs_e;
      active = ctrl.run && h_ff < eff.h_act && v_ff < eff.v_act;
      nxt_h = h_ff;
      nxt_v = v_ff;
      if (!ctrl.run)
      begin
         nxt_h = '0;
         nxt_v = '0;
      end
      else if (h_ff + 1'b1 >= eff.h_tot)
      begin
         nxt_h = '0;
         nxt_v = (v_ff + 1'b1 >= eff.v_tot) ? '0 : v_ff + 1'b1;
      end
      else
         nxt_h = h_ff + 1'b1;
      // Separate line and frame sync only, polarity after the compare
      nxt_hs = ctrl.hs_en ? (hs_raw ~^ ctrl.hs_pol) : ctrl.hs_idle;
      nxt_vs = ctrl.vs_en ? (vs_raw ~^ ctrl.vs_pol) : ctrl.vs_idle;
      // One pixel per clock; underrun and blanking show black
      nxt_px = (active && f_valid) ? f_data : '0;
      nxt_vsr = vs_raw;
      nxt_d1 = d1_ff;
      nxt_d1n = d1n_ff;
      nxt_d1v = d1v_ff && !srd_ff;
      if (ctrl.ddc1_en && vs_raw && !vsr_ff)
      begin
         nxt_d1 = {d1_ff[6:0], monitor_channel_data_i};
         nxt_d1n = d1n_ff + 1'b1;
         if (d1n_ff == 3'd7)
            nxt_d1v = 1'b1;
      end
      tick = q_ff == 16'(DDC_QTR - 1);
      nxt_q = (st_ff[0] || tick) ? 16'h0000 : q_ff + 1'b1;
      nxt_st = st_ff;
      nxt_ph = ph_ff;
      nxt_bit = bit_ff;
      nxt_byt = byt_ff;
      nxt_nak = nak_ff;
      nxt_sh = sh_ff;
      nxt_rx = rx_ff;
      nxt_sclo = sclo_ff;
      nxt_sdao = sdao_ff;
      case (st_ff)
         ADS_ST_IDLE:
         begin
            nxt_sclo = rf_ff[10][0] && rf_ff[10][1];
            nxt_sdao = rf_ff[10][0] && rf_ff[10][2];
            if (go_ff)
            begin
               nxt_st = ADS_ST_START;
               nxt_ph = 2'd0;
               nxt_nak = 1'b0;
               nxt_sh = {rf_ff[8][6:0], rf_ff[8][7]}; // Address first, direction bit last
               nxt_sclo = 1'b0;
               nxt_sdao = 1'b0;
            end
         end
         ADS_ST_START:
            if (tick)
            begin
               nxt_ph = ph_ff + 1'b1;
               nxt_sdao = 1'b1;
               nxt_sclo = ph_ff == 2'd1;
               if (ph_ff == 2'd1)
               begin
                  nxt_st = ADS_ST_XFER;
                  nxt_ph = 2'd0;
                  nxt_bit = 4'd0;
                  nxt_byt = 1'b0;
               end
            end
         ADS_ST_XFER:
            if (tick)
            begin
               nxt_ph = ph_ff + 1'b1;
               if (ph_ff == 2'd0)
                  nxt_sdao = bit_ff != 4'd8 && !(byt_ff && rf_ff[8][7]) && !sh_ff[7];
               nxt_sclo = ph_ff == 2'd3 || ph_ff == 2'd0 && sclo_ff;
               if (ph_ff == 2'd2 && bit_ff != 4'd8)
                  nxt_sh = {sh_ff[6:0], monitor_channel_data_i};
               if (ph_ff == 2'd2 && bit_ff == 4'd8 && monitor_channel_data_i && !(byt_ff && rf_ff[8][7]))
                  nxt_nak = 1'b1;
               if (ph_ff == 2'd3)
               begin
                  nxt_bit = bit_ff + 1'b1;
                  if (bit_ff == 4'd7 && byt_ff)
                     nxt_rx = sh_ff;
                  if (bit_ff == 4'd8)
                  begin
                     nxt_bit = 4'd0;
                     nxt_byt = 1'b1;
                     nxt_sh = rf_ff[8][15:8];
                     // Data pulled low only once the clock is already low
                     if (byt_ff || nak_ff)
                        nxt_st = ADS_ST_STOP;
                  end
               end
            end
         ADS_ST_STOP:
            if (tick)
            begin
               nxt_ph = ph_ff + 1'b1;
               // Clock kept low a full half bit, so the last low phase is not short
               nxt_sclo = ph_ff == 2'd0;
               nxt_sdao = ph_ff != 2'd2;
               if (ph_ff == 2'd2)
                  nxt_st = ADS_ST_IDLE;
            end
         default:
            nxt_st = ADS_ST_IDLE;
      endcase
      nxt_gap = (nxt_sclo != sclo_ff) ? 18'h00000 : gap_ff + {17'h00000, gap_ff != 18'h3FFFF};
   end
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         gap_ff <= '0;
         h_ff <= '0;
         v_ff <= '0;
         hs_ff <= 1'b1;
         vs_ff <= 1'b1;
         vsr_ff <= 1'b0;
         px_ff <= '0;
         st_ff <= ADS_ST_IDLE;
         q_ff <= '0;
         ph_ff <= '0;
         bit_ff <= '0;
         byt_ff <= 1'b0;
         nak_ff <= 1'b0;
         sh_ff <= '0;
         rx_ff <= '0;
         sclo_ff <= 1'b0;
         sdao_ff <= 1'b0;
         d1_ff <= '0;
         d1n_ff <= '0;
         d1v_ff <= 1'b0;
      end
      else
      begin
         gap_ff <= nxt_gap;
         h_ff <= nxt_h;
         v_ff <= nxt_v;
         hs_ff <= nxt_hs;
         vs_ff <= nxt_vs;
         vsr_ff <= nxt_vsr;
         px_ff <= nxt_px;
         st_ff <= nxt_st;
         q_ff <= nxt_q;
         ph_ff <= nxt_ph;
         bit_ff <= nxt_bit;
         byt_ff <= nxt_byt;
         nak_ff <= nxt_nak;
         sh_ff <= nxt_sh;
         rx_ff <= nxt_rx;
         sclo_ff <= nxt_sclo;
         sdao_ff <= nxt_sdao;
         d1_ff <= nxt_d1;
         d1n_ff <= nxt_d1n;
         d1v_ff <= nxt_d1v;
      end
   end
   assign hsync = hs_ff;
   assign vsync = vs_ff;
   assign pix_out = px_ff;
   // Open drain: the pins are only ever pulled low
   assign monitor_channel_clock_o = 1'b0;
   assign monitor_channel_data_o = 1'b0;
   assign monitor_channel_clock_oe = sclo_ff;
   assign monitor_channel_data_oe = sdao_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_hs_idle_level: assert property (!ctrl.hs_en |=> hsync == $past(ctrl.hs_idle))
      else $error("line sync not at idle level");
   a_sync_reset_high: assert property ($past(rst) |-> hsync && vsync && !ctrl.hs_en && !ctrl.vs_en)
      else $error("syncs not high and disabled after reset");
   a_hs_polarity: assert property (ctrl.hs_en && hs_raw |=> hsync == $past(ctrl.hs_pol))
      else $error("line sync polarity wrong");
   a_vs_polarity: assert property (ctrl.vs_en && !vs_raw |=> vsync != $past(ctrl.vs_pol))
      else $error("frame sync polarity wrong");
   a_vga_timing: assert property (ctrl.vga_mode |-> eff.h_tot == chr(rf_ff[5][7:0]))
      else $error("legacy timing not used");
   a_hs_start_pos: assert property ($rose(hs_raw) && $stable(ctrl.run) && $stable(eff) |-> h_ff == eff.hs_s)
      else $error("line sync starts at wrong count");
   a_ddc_clk_rate: assert property (!st_ff[0] && nxt_sclo != sclo_ff |-> gap_ff >= 18'(2 * DDC_QTR - 1))
      else $error("serial clock too fast");
   a_pix_blank: assert property (!active |=> pix_out == '0)
      else $error("pixel outside active area");
endmodule

// ===== verif/ads_monitor.sv
// Monitor side of the display data channel
`timescale 1ns/1ps
module ads_monitor
#(
   parameter logic [6:0] ADDR = 7'h50
)
(
   input  wire logic       clk_oe,
   input  wire logic       data_oe,
   output wire logic       scl,
   output wire logic       sda,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte
);
   logic       pull = 1'h0;
   logic       sel  = 1'h0;
   logic       rdm  = 1'h0;
   logic [4:0] cnt  = 5'h0;
   logic [7:0] sh   = 8'h0;
   // Pull-ups, so a released line reads high
   assign scl = !clk_oe;
   assign sda = !(data_oe || pull);
   always @(negedge sda)
      if (scl)
         cnt = 5'h0;
   always @(posedge sda)
      if (scl)
         sel = 1'h0;
   always @(posedge scl)
   begin
      sh = {sh[6:0], sda};
      cnt = cnt + 5'h1;
   end
   // Only our own address is acknowledged, others see a nack
   always @(negedge scl)
   begin
      pull = 1'h0;
      if (cnt == 5'h8)
      begin
         sel = (sh[7:1] == ADDR);
         rdm = sh[0];
         pull = sel;
      end
      else if (sel && rdm && cnt >= 5'h9 && cnt <= 5'h10)
         pull = !tx_byte[5'h10 - cnt];
      else if (sel && !rdm && cnt == 5'h11)
      begin
         rx_byte = sh;
         pull = 1'h1;
      end
   end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the analog display sync block
`timescale 1ns/1ps
module tb_top;
   import ads_pkg::*;
   logic        core_clk = 1'h0;
   logic        rst      = 1'h1;
   logic [7:0]  aa       = 8'h0;
   logic [7:0]  ra       = 8'h0;
   logic [31:0] wd       = 32'h0;
   logic        av       = 1'h0;
   logic        wv       = 1'h0;
   logic        rv       = 1'h0;
   logic        pv       = 1'h0;
   ads_pixel_t  pd       = '0;
   ads_pixel_t  po;
   logic [31:0] rdat;
   logic [1:0]  br, rr;
   logic        awr, wrd, bv, arr, rval, prdy, hs, vs, ck_oe, dt_oe;
   logic [7:0]  mrx;
   wire         scl, sda;
   int          errors   = 0;
   int          compares = 0;
   always #2.5 core_clk = ~core_clk;
   ads_top #(.DDC_QTR(4)) uut
   (
      .core_clk(core_clk), .rst(rst), .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(1'h1), .s_axi_araddr(ra), .s_axi_arvalid(rv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rval), .s_axi_rready(1'h1), .pix_in_valid(pv),
      .pix_in_data(pd), .pix_in_ready(prdy), .pix_out(po), .hsync(hs), .vsync(vs),
      .monitor_channel_clock_i(scl), .monitor_channel_clock_o(), .monitor_channel_clock_oe(ck_oe),
      .monitor_channel_data_i(sda), .monitor_channel_data_o(), .monitor_channel_data_oe(dt_oe)
   );
   ads_monitor mon (.clk_oe(ck_oe), .data_oe(dt_oe), .scl(scl), .sda(sda), .tx_byte(8'h3C), .rx_byte(mrx));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Response channels stay ready, so only the requests are handshaked here
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      aa <= a;
      wd <= d;
      av <= 1'h1;
      wv <= 1'h1;
      do
      begin
         @(posedge core_clk);
         if (awr)
            av <= 1'h0;
         if (wrd)
            wv <= 1'h0;
      end
      while (!bv);
      chk(32'(br), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
      ra <= a;
      rv <= 1'h1;
      do
      begin
         @(posedge core_clk);
         if (arr)
            rv <= 1'h0;
      end
      while (!rval);
      d = rdat;
      chk(32'(rr), 32'(er));
   endtask
   function automatic ads_pixel_t pat(input int i);
      return {8'(8'h10 + i), 8'(8'h40 + i), 8'(8'h80 + i)};
   endfunction
   task automatic meas(output int h, output int v);
      h = 0;
      v = 0;
      repeat (120)
      begin
         @(posedge core_clk);
         h += hs;
         v += vs;
      end
   endtask
   task automatic per(output int p);
      time t0;
      @(posedge hs);
      t0 = $time;
      @(posedge hs);
      p = int'(($time - t0) / 5);
   endtask
   task automatic t_reset;
      logic [31:0] d;
      chk(32'({hs, vs}), 32'h3);
      rst <= 1'h0;
      repeat (8) @(posedge core_clk);
      chk(32'({hs, vs}), 32'h3);
      rd(8'h00, d);
      chk(d, 32'h30);
      rd(8'h2C, d, 2'h2);
      chk(d, 32'h0);
      wr(8'h2C, 32'hFFFF_FFFF, 2'h2);
   endtask
   // Fill the buffer while the output is stopped, then drain it into one line
   task automatic t_pixels;
      ads_pixel_t q[$];
      int n;
      wr(8'h04, 32'h0014_0008);
      wr(8'h08, 32'h000F_000C);
      wr(8'h0C, 32'h0006_0004);
      wr(8'h10, 32'h0005_0004);
      pv <= 1'h1;
      pd <= pat(0);
      n = 0;
      repeat (12)
      begin
         @(posedge core_clk);
         if (prdy)
         begin
            n++;
            pd <= pat(n);
         end
      end
      pv <= 1'h0;
      chk(32'(n), 32'h8);
      fork
         wr(8'h00, 32'h87);
         repeat (60)
         begin
            @(posedge core_clk);
            if (po !== 24'h0)
               q.push_back(po);
         end
      join
      chk(32'(q.size()), 32'h8);
      foreach (q[i])
         chk(32'(q[i]), 32'(pat(i)));
   endtask
   // One frame is 120 cycles, so each window holds exactly one frame
   task automatic t_sync;
      logic [31:0] c[4] = '{32'h87, 32'h8B, 32'h90, 32'hA0};
      int eh[4] = '{32'h12, 32'h66, 32'h78, 32'h0};
      int ev[4] = '{32'h64, 32'h14, 32'h0, 32'h78};
      int h, v;
      foreach (c[i])
      begin
         wr(8'h00, c[i]);
         repeat (4) @(posedge core_clk);
         meas(h, v);
         chk(32'(h), 32'(eh[i]));
         chk(32'(v), 32'(ev[i]));
      end
   endtask
   task automatic t_vga;
      int p1, p2;
      wr(8'h00, 32'hC7);
      per(p1);
      wr(8'h04, 32'h0018_0008);
      per(p2);
      chk(32'(p1), 32'h320);
      chk(32'(p2), 32'(p1));
   endtask
   task automatic ddc(input logic [31:0] cmd, output logic [31:0] d);
      wr(8'h20, cmd);
      repeat (4) @(posedge core_clk);
      do
         rd(8'h24, d);
      while (d[0]);
   endtask
   task automatic t_serial;
      logic [31:0] d;
      ddc(32'hA550, d);
      chk(32'(d[1]), 32'h0);
      chk(32'(mrx), 32'hA5);
      ddc(32'hD0, d);
      chk(32'(d[9:2]), 32'h3C);
      ddc(32'h51, d);
      chk(32'(d[1]), 32'h1);
   endtask
   task automatic t_ddc1;
      logic [31:0] d;
      wr(8'h00, 32'h187);
      repeat (1400) @(posedge core_clk);
      rd(8'h24, d);
      chk(32'(d[18:10]), 32'h1FF);
      rd(8'h24, d);
      chk(32'(d[18]), 32'h0);
   endtask
   task automatic t_pins;
      logic [31:0] d;
      wr(8'h28, 32'h3);
      rd(8'h28, d);
      chk(32'(d[4:3]), 32'h2);
      chk(32'({ck_oe, dt_oe}), 32'h2);
      wr(8'h28, 32'h5);
      rd(8'h28, d);
      chk(32'(d[4:3]), 32'h1);
      wr(8'h28, 32'h0);
   endtask
   initial
   begin
      repeat (20) @(posedge core_clk);
      t_reset;
      t_pixels;
      t_sync;
      t_vga;
      t_serial;
      t_ddc1;
      t_pins;
      close_out;
   end
   initial
   begin
      #400000;
      errors++;
      close_out;
   end
endmodule
